// *** rtl/bus_clk_div.sv ***
// Bus clock divider: one-cycle tick every 2**code source enables.
// Assumes source enable synchronous to mclk_in.
`timescale 1ns/1ps
`include "clk_ctrl_defines.svh"
module bus_clk_div (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic src_en_in,
	div_if.divider dv
);
	import clk_ctrl_pkg::*;
	logic [6:0] cnt_reg, cnt_next;
	div_code_t code_reg, code_next;
	logic tick_reg, tick_next;
	function automatic logic [6:0] terminal(input div_code_t c);
		terminal = 7'(({7'h0, 1'b1} << c) - 8'h01);
	endfunction
	always_comb begin
		cnt_next = cnt_reg;
		code_next = code_reg;
		tick_next = 1'b0;
		if (src_en_in) begin
			if (cnt_reg >= terminal(code_reg)) begin
				cnt_next = 7'h00;
				tick_next = 1'b1;
				code_next = dv.code;
			end else begin
				cnt_next = 7'(cnt_reg + 7'h01);
			end
		end
	end
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_reg <= 7'h00;
			code_reg <= `RST_BUS_DIV;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			code_reg <= code_next;
			tick_reg <= tick_next;
		end
	end
	assign dv.tick = tick_reg;
endmodule

// *** rtl/clk_ctrl_defines.svh ***
// Register offsets, field positions and reset values of the clock generator control registers.
// Assumes inclusion by bare name from the design files.
`ifndef CLK_CTRL_DEFINES_SVH
`define CLK_CTRL_DEFINES_SVH
`define OFS_BUS_DIV_PWR 16'h3039
`define OFS_COARSE_TRIM 16'h303a
`define OFS_MON_FINE 16'h303b
`define OFS_LOCK_STATUS 16'h303c
`define OFS_IRQ_STATUS 16'h3040
`define OFS_IRQ_MASK 16'h3044
`define RST_BUS_DIV 3'h1
`define RST_LOOP_PD 1'h0
`define RST_COARSE_TRIM 8'h80
`define BIT_LOCK_LOSS 7
`define BIT_CLK_LOSS 6
`define SEL_LOOP 2'h0
`define SEL_INTERNAL 2'h1
`define SEL_EXTERNAL 2'h2
`endif

// *** rtl/clk_ctrl_pkg.sv ***
// Types shared by the clock generator control block.
// Assumes the defines header is compiled with it.
package clk_ctrl_pkg;
	typedef logic [2:0] div_code_t;
	typedef logic [1:0] src_sel_t;
	typedef logic [7:0] trim_t;
endpackage

// *** rtl/clk_gen_ctrl.sv ***
// How it works
// - The bus clock is the selected source divided by two to the power of the 3-bit divider code.
// - With the bypass power-down bit set the loop is disabled in bypass modes unless debug is active.
// - Reserved bits read as zero and ignore writes.
// - The coarse trim is a binary weighted field where larger values lengthen the period.
// - The coarse trim has no guaranteed reset value.
// - The fine trim bit lengthens the period by the smallest step when set and shortens it when clear.
// - Outside debug mode the fine trim bit is loaded from a factory value on the first clock after reset release.
// - An interrupt is requested when the lock-loss enable and the lock-loss flag are both set.
// - With the clock monitor enabled, loss of the external clock raises a reset request.
// - A 2-bit select picks the loop output, internal or external reference; code 11 is reserved.
// - The lock-loss flag clears on reset or on a write of 1 while set; writing 0 does nothing.
// Register block on APB, 8-bit registers in the low byte of each word.
// Assumes all inputs synchronous to mclk_in.
`timescale 1ns/1ps
`include "clk_ctrl_defines.svh"
module clk_gen_ctrl (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [15:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire clk_ctrl_pkg::src_sel_t clock_source_select_in,
	input wire logic loop_clk_en_in,
	input wire logic int_ref_en_in,
	input wire logic ext_ref_en_in,
	input wire logic background_debug_mode_in,
	input wire logic factory_fine_trim_in,
	input wire logic lock_loss_event_in,
	input wire logic ext_clock_lost_in,
	output logic bus_clk_tick_out,
	output logic loop_disable_out,
	output clk_ctrl_pkg::trim_t slow_ref_coarse_trim_out,
	output logic slow_ref_fine_trim_out,
	output logic clock_reset_req_out,
	output logic irq_out
);
	import clk_ctrl_pkg::*;
	div_if dv();
	logic src_en_reg, src_en_next;
	// Register state
	div_code_t bus_divider_code_reg, bus_divider_code_next;
	logic bypass_loop_power_down_reg, bypass_loop_power_down_next;
	trim_t coarse_reg, coarse_next;
	logic lock_loss_irq_enable_reg, lock_loss_irq_enable_next;
	logic ext_clock_monitor_enable_reg, ext_clock_monitor_enable_next;
	logic fine_reg, fine_next;
	logic fine_loaded_reg, fine_loaded_next;
	logic lock_loss_sticky_flag_reg, lock_loss_sticky_flag_next;
	logic [7:0] irq_status_reg, irq_status_next;
	logic [7:0] irq_mask_reg, irq_mask_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic loop_dis_reg, loop_dis_next;
	logic rst_req_reg, rst_req_next;
	logic irq_reg, irq_next;
	logic setup, wr, rd;
	logic [7:0] wbyte;

	function automatic logic mapped(input logic [15:0] a);
		mapped = (a == `OFS_BUS_DIV_PWR) || (a == `OFS_COARSE_TRIM) || (a == `OFS_MON_FINE) ||
			(a == `OFS_LOCK_STATUS) || (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_MASK);
	endfunction

	assign dv.code = bus_divider_code_reg;

	bus_clk_div u_div (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.src_en_in(src_en_reg),
		.dv(dv)
	);

	always_comb begin
		setup = psel_in && !penable_in;
		wr = setup && pwrite_in && mapped(paddr_in);
		rd = setup && !pwrite_in;
		wbyte = pwdata_in[7:0];
		unique case (clock_source_select_in)
			`SEL_LOOP: src_en_next = loop_clk_en_in;
			`SEL_INTERNAL: src_en_next = int_ref_en_in;
			`SEL_EXTERNAL: src_en_next = ext_ref_en_in;
			default: src_en_next = 1'b0;
		endcase
	end

	// Writes and reads complete in the cycle after setup; pready asserts for one access cycle.
	always_comb begin
		bus_divider_code_next = bus_divider_code_reg;
		bypass_loop_power_down_next = bypass_loop_power_down_reg;
		coarse_next = coarse_reg;
		lock_loss_irq_enable_next = lock_loss_irq_enable_reg;
		ext_clock_monitor_enable_next = ext_clock_monitor_enable_reg;
		fine_next = fine_reg;
		fine_loaded_next = 1'b1;
		lock_loss_sticky_flag_next = lock_loss_sticky_flag_reg;
		irq_status_next = irq_status_reg;
		irq_mask_next = irq_mask_reg;
		// Every access starts from zero so a write never shows stale read data with pready
		prdata_next = setup ? 32'h0000_0000 : prdata_reg;
		pready_next = setup;
		pslverr_next = setup && !mapped(paddr_in);
		// First clock after reset release takes the factory fine trim unless in debug
		if (!fine_loaded_reg && !background_debug_mode_in) begin
			fine_next = factory_fine_trim_in;
		end
		if (wr) begin
			unique case (paddr_in)
				`OFS_BUS_DIV_PWR: begin
					bus_divider_code_next = wbyte[7:5];
					bypass_loop_power_down_next = wbyte[4];
				end
				`OFS_COARSE_TRIM: coarse_next = wbyte;
				`OFS_MON_FINE: begin
					lock_loss_irq_enable_next = wbyte[7];
					ext_clock_monitor_enable_next = wbyte[5];
					fine_next = wbyte[0];
				end
				`OFS_LOCK_STATUS: begin
					if (wbyte[7] && lock_loss_sticky_flag_reg) begin
						lock_loss_sticky_flag_next = 1'b0;
					end
				end
				`OFS_IRQ_MASK: irq_mask_next = wbyte & 8'hc0;
				default: begin
				end
			endcase
		end
		if (rd) begin
			prdata_next = 32'h0000_0000;
			unique case (paddr_in)
				`OFS_BUS_DIV_PWR: prdata_next[7:0] = {bus_divider_code_reg, bypass_loop_power_down_reg, 4'h0};
				`OFS_COARSE_TRIM: prdata_next[7:0] = coarse_reg;
				`OFS_MON_FINE: prdata_next[7:0] = {lock_loss_irq_enable_reg, 1'b0,
					ext_clock_monitor_enable_reg, 4'h0, fine_reg};
				`OFS_LOCK_STATUS: prdata_next[7:0] = {lock_loss_sticky_flag_reg, 7'h00};
				`OFS_IRQ_STATUS: begin
					prdata_next[7:0] = irq_status_reg;
					irq_status_next = 8'h00;
				end
				`OFS_IRQ_MASK: prdata_next[7:0] = irq_mask_reg;
				default: prdata_next = 32'h0000_0000;
			endcase
		end
		// Events set after any clear so a coincident event survives
		if (lock_loss_event_in) begin
			lock_loss_sticky_flag_next = 1'b1;
			irq_status_next[`BIT_LOCK_LOSS] = 1'b1;
		end
		if (ext_clock_lost_in && ext_clock_monitor_enable_reg) begin
			irq_status_next[`BIT_CLK_LOSS] = 1'b1;
		end
	end

	always_comb begin
		// Loop stays alive in bypass during debug so the debugger keeps its clock
		loop_dis_next = bypass_loop_power_down_reg && !background_debug_mode_in &&
			(clock_source_select_in == `SEL_INTERNAL || clock_source_select_in == `SEL_EXTERNAL);
		rst_req_next = ext_clock_monitor_enable_reg && ext_clock_lost_in;
		irq_next = (lock_loss_irq_enable_reg && lock_loss_sticky_flag_reg) ||
			|(irq_status_reg & irq_mask_reg);
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			src_en_reg <= 1'b0;
			bus_divider_code_reg <= `RST_BUS_DIV;
			bypass_loop_power_down_reg <= `RST_LOOP_PD;
			lock_loss_irq_enable_reg <= 1'b0;
			ext_clock_monitor_enable_reg <= 1'b0;
			fine_reg <= 1'b0;
			fine_loaded_reg <= 1'b0;
			lock_loss_sticky_flag_reg <= 1'b0;
			irq_status_reg <= 8'h00;
			irq_mask_reg <= 8'h00;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			loop_dis_reg <= 1'b0;
			rst_req_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			src_en_reg <= src_en_next;
			bus_divider_code_reg <= bus_divider_code_next;
			bypass_loop_power_down_reg <= bypass_loop_power_down_next;
			lock_loss_irq_enable_reg <= lock_loss_irq_enable_next;
			ext_clock_monitor_enable_reg <= ext_clock_monitor_enable_next;
			fine_reg <= fine_next;
			fine_loaded_reg <= fine_loaded_next;
			lock_loss_sticky_flag_reg <= lock_loss_sticky_flag_next;
			irq_status_reg <= irq_status_next;
			irq_mask_reg <= irq_mask_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			loop_dis_reg <= loop_dis_next;
			rst_req_reg <= rst_req_next;
			irq_reg <= irq_next;
		end
	end

	// Coarse trim has no reset: the analog trim holds whatever it powered up with
	always_ff @(posedge mclk_in) begin
		coarse_reg <= coarse_next;
	end

	assign prdata_out = prdata_reg;
	assign pready_out = pready_reg;
	assign pslverr_out = pslverr_reg;
	assign bus_clk_tick_out = dv.tick;
	assign loop_disable_out = loop_dis_reg;
	assign slow_ref_coarse_trim_out = coarse_reg;
	assign slow_ref_fine_trim_out = fine_reg;
	assign clock_reset_req_out = rst_req_reg;
	assign irq_out = irq_reg;
endmodule

// *** rtl/div_if.sv ***
// Carrier between the register block and the bus divider.
// Assumes one clock domain.
`timescale 1ns/1ps
interface div_if;
	logic [2:0] code;
	logic tick;
	modport ctrl(output code, input tick);
	modport divider(input code, output tick);
endinterface

// *** testbench/clk_gen_ctrl_sva.sv ***
// Checker for the clock generator control block, bound to its top module.
// Assumes the defines header and the package are compiled first.
`timescale 1ns/1ps
`include "clk_ctrl_defines.svh"
module clk_gen_ctrl_sva (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [15:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire clk_ctrl_pkg::src_sel_t clock_source_select_in,
	input wire logic background_debug_mode_in,
	input wire logic factory_fine_trim_in,
	input wire logic ext_clock_lost_in,
	input wire logic bus_clk_tick_out,
	input wire logic loop_disable_out,
	input wire logic slow_ref_fine_trim_out,
	input wire logic clock_reset_req_out,
	input wire logic irq_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out) else $error("no ready");
	a_ready_single: assert property (pready_out |=> !pready_out) else $error("ready too long");
	a_unmapped_zero: assert property (pslverr_out |-> pready_out && prdata_out == 0) else $error("bad error");
	a_div_rsvd_zero: assert property (pready_out && paddr_in == `OFS_BUS_DIV_PWR |->
		prdata_out[3:0] == 0 && prdata_out[31:8] == 0) else $error("reserved bits set");
	a_mon_rsvd_zero: assert property (pready_out && paddr_in == `OFS_MON_FINE |->
		prdata_out[6] == 0 && prdata_out[4:1] == 0) else $error("reserved bits set");
	a_debug_keeps_loop: assert property (background_debug_mode_in |=> !loop_disable_out)
		else $error("loop off in debug");
	a_loop_src_keeps: assert property (clock_source_select_in == `SEL_LOOP |=> !loop_disable_out)
		else $error("loop off while used");
	a_no_loss_quiet: assert property (!ext_clock_lost_in |=> !clock_reset_req_out)
		else $error("reset request without loss");
	a_fine_trim_load: assert property ($past(reset_in) && !background_debug_mode_in |=>
		slow_ref_fine_trim_out == $past(factory_fine_trim_in)) else $error("fine trim not loaded");
	a_rsvd_src_idle: assert property (clock_source_select_in == 2'h3 [*8] |=> !bus_clk_tick_out)
		else $error("tick from reserved source");
	c_error: cover property (pslverr_out);
	c_irq: cover property (irq_out);
	c_reset_req: cover property (clock_reset_req_out);
	c_loop_off: cover property (loop_disable_out);
endmodule
bind clk_gen_ctrl clk_gen_ctrl_sva chk (.mclk_in, .reset_in, .psel_in, .penable_in, .paddr_in, .prdata_out,
	.pready_out, .pslverr_out, .clock_source_select_in, .background_debug_mode_in, .factory_fine_trim_in,
	.ext_clock_lost_in, .bus_clk_tick_out, .loop_disable_out, .slow_ref_fine_trim_out, .clock_reset_req_out,
	.irq_out);

// *** testbench/clk_gen_ctrl_test.sv ***
// Directed bench for the clock generator control block over APB.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
`include "clk_ctrl_defines.svh"
module clk_gen_ctrl_test;
	import clk_ctrl_pkg::*;
	logic mclk_in = 0, reset_in = 1, psel = 0, pen = 0, pwr = 0, prdy, perr, tick, ldis, ftrim, rreq, irq;
	logic dbg = 0, ff = 1, lle = 0, ecl = 0, ie = 1, le = 0, xe = 0, e;
	logic [15:0] pa = 16'h0000;
	logic [31:0] pwd = 32'h0000_0000, prd, r;
	src_sel_t sel = 2'h1;
	trim_t ctrim;
	int fail_count = 0, n_checks = 0, k, t;
	clk_gen_ctrl uut (.mclk_in(mclk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
		.clock_source_select_in(sel), .loop_clk_en_in(le), .int_ref_en_in(ie), .ext_ref_en_in(xe),
		.background_debug_mode_in(dbg), .factory_fine_trim_in(ff), .lock_loss_event_in(lle),
		.ext_clock_lost_in(ecl), .bus_clk_tick_out(tick), .loop_disable_out(ldis),
		.slow_ref_coarse_trim_out(ctrim), .slow_ref_fine_trim_out(ftrim), .clock_reset_req_out(rreq), .irq_out(irq));
	initial begin
		forever #20 mclk_in = ~mclk_in;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	// Request held until the edge that samples pready; an idle edge precedes every setup
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk_in);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge mclk_in);
		pen <= 1;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (prdy !== 1'b1 && n < 50);
		r = prd;
		e = perr;
		psel <= 0;
		pen <= 0;
		if (prdy !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t no ready", $time);
			end_of_test();
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		xfer(0, a, 32'h0000_0000);
		chk(r, exp, "read data");
	endtask
	task automatic ticks(input int cyc);
		t = 0;
		repeat (cyc) begin
			@(posedge mclk_in);
			t += (tick === 1'b1);
		end
	endtask
	task automatic pulse_loss();
		@(posedge mclk_in);
		lle <= 1;
		@(posedge mclk_in);
		lle <= 0;
		repeat (3) @(posedge mclk_in);
	endtask
	initial begin
		repeat (8) @(posedge mclk_in);
		reset_in <= 0;
		rd(`OFS_BUS_DIV_PWR, 32'h0000_0020);
		rd(`OFS_MON_FINE, 32'h0000_0001);
		xfer(1, `OFS_BUS_DIV_PWR, 32'hFFFF_FFFF);
		rd(`OFS_BUS_DIV_PWR, 32'h0000_00F0);
		xfer(1, `OFS_MON_FINE, 32'hFFFF_FFFF);
		rd(`OFS_MON_FINE, 32'h0000_00A1);
		chk(ftrim, 1, "fine trim set");
		xfer(1, `OFS_COARSE_TRIM, 32'h0000_005A);
		rd(`OFS_COARSE_TRIM, 32'h0000_005A);
		chk(ctrim, 32'h0000_005A, "coarse trim");
		xfer(0, 16'h3050, 32'h0000_0000);
		chk({r[31:1], e}, 32'h0000_0001, "unmapped");
		$display("register test done");
		for (k = 0; k < 8; k++) begin
			xfer(1, `OFS_BUS_DIV_PWR, 32'(k) << 5);
			ticks(256);
			ticks(256);
			chk(t, 256 >> k, "tick count");
		end
		// Unselected enables are held high for the internal and reserved selects, so only the selected enable may reach the divider
		for (k = 0; k < 4; k++) begin
			sel <= 2'(k);
			le <= (k != 2);
			xe <= (k != 0);
			ie <= (k == 3);
			repeat (2) @(posedge mclk_in);
			ticks(256);
			chk(t, (k == 0 || k == 2) ? 256 >> 7 : 0, "ticks from selected source");
		end
		ie <= 1;
		$display("divider test done");
		sel <= `SEL_INTERNAL;
		xfer(1, `OFS_BUS_DIV_PWR, 32'h0000_0010);
		repeat (3) @(posedge mclk_in);
		chk(ldis, 1, "loop off in bypass");
		dbg <= 1;
		repeat (3) @(posedge mclk_in);
		chk(ldis, 0, "loop on in debug");
		dbg <= 0;
		sel <= `SEL_EXTERNAL;
		repeat (3) @(posedge mclk_in);
		chk(ldis, 1, "loop off in external bypass");
		sel <= `SEL_LOOP;
		repeat (3) @(posedge mclk_in);
		chk(ldis, 0, "loop on while selected");
		sel <= `SEL_INTERNAL;
		xfer(1, `OFS_BUS_DIV_PWR, 32'h0000_0000);
		repeat (3) @(posedge mclk_in);
		chk(ldis, 0, "loop on without power down");
		$display("power test done");
		xfer(1, `OFS_MON_FINE, 32'h0000_0080);
		chk(irq, 0, "irq without flag");
		chk(ftrim, 0, "fine trim clear");
		pulse_loss();
		chk(irq, 1, "irq on lock loss");
		rd(`OFS_LOCK_STATUS, 32'h0000_0080);
		xfer(1, `OFS_LOCK_STATUS, 32'h0000_0000);
		rd(`OFS_LOCK_STATUS, 32'h0000_0080);
		xfer(1, `OFS_LOCK_STATUS, 32'h0000_0080);
		rd(`OFS_LOCK_STATUS, 32'h0000_0000);
		chk(irq, 0, "irq after flag clear");
		rd(`OFS_IRQ_STATUS, 32'h0000_0080);
		rd(`OFS_IRQ_STATUS, 32'h0000_0000);
		xfer(1, `OFS_MON_FINE, 32'h0000_0000);
		xfer(1, `OFS_IRQ_MASK, 32'h0000_0080);
		pulse_loss();
		chk(irq, 1, "masked status irq");
		rd(`OFS_IRQ_STATUS, 32'h0000_0080);
		repeat (2) @(posedge mclk_in);
		chk(irq, 0, "irq after status read");
		$display("interrupt test done");
		sel <= `SEL_EXTERNAL;
		xfer(1, `OFS_MON_FINE, 32'h0000_0020);
		ecl <= 1;
		repeat (3) @(posedge mclk_in);
		chk(rreq, 1, "reset request");
		xfer(1, `OFS_MON_FINE, 32'h0000_0000);
		repeat (3) @(posedge mclk_in);
		chk(rreq, 0, "monitor off");
		ecl <= 0;
		rd(`OFS_IRQ_STATUS, 32'h0000_0040);
		$display("monitor test done");
		end_of_test();
	end
endmodule
